//--- bcd_calendar_rtc_backup_tb_top.sv
`timescale 1ns/1ns
module bcd_calendar_rtc_backup_tb_top;
  import rtcbk_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  typedef struct {int sel; int due; logic [67:0] v;} rtcbk_note_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  rtcbk_ctrl_t ctrl = '0;
  logic cal_load = 1'b0;
  rtcbk_time_t cal_wdata = '0;
  logic shift_req = 1'b0;
  rtcbk_shift_t shift_cmd = '0;
  rtcbk_alarm_t al0 = '0;
  rtcbk_alarm_t al1 = '0;
  logic [3:0] pins = 4'h0;
  logic ref_pin = 1'b0;
  logic [1:0] alarm_clr = 2'h0;
  logic [2:0] tamper_clr = 3'h0;
  logic ts_clr = 1'b0;
  logic bkp_we = 1'b0;
  logic [3:0] bkp_widx = 4'h0;
  logic [31:0] bkp_wdata = 32'h0;
  logic [3:0] bkp_ridx = 4'h0;
  logic [31:0] bkp_rdata;
  rtcbk_time_t cal_time;
  rtcbk_time_t ts_time;
  logic [1:0] alarm_flag;
  logic [2:0] tamper_flag;
  logic ts_flag;
  logic ts_ovf;
  logic wake;
  logic [31:0] mem [16];
  rtcbk_time_t t0;
  rtcbk_note_t q[$];
  int cyc = 0;
  int failures = 0;
  int samples_checked = 0;

  rtcbk_top rtcbk_top_i (
    .core_clk(core_clk), .rst(rst), .ctrl(ctrl), .cal_load(cal_load),
    .cal_wdata(cal_wdata), .shift_req(shift_req), .shift_cmd(shift_cmd),
    .alarm_first(al0), .alarm_second(al1), .timestamp_trigger_input(pins[3]),
    .tamper_input_first(pins[0]), .tamper_input_second(pins[1]),
    .tamper_input_third(pins[2]), .ref_clk_input(ref_pin), .alarm_clr(alarm_clr),
    .tamper_clr(tamper_clr), .ts_clr(ts_clr), .bkp_we(bkp_we), .bkp_widx(bkp_widx),
    .bkp_wdata(bkp_wdata), .bkp_ridx(bkp_ridx), .bkp_rdata(bkp_rdata),
    .cal_time(cal_time), .ts_time(ts_time), .alarm_flag(alarm_flag),
    .tamper_flag(tamper_flag), .ts_flag(ts_flag), .ts_ovf(ts_ovf), .wake(wake)
  );

  always #5 core_clk = ~core_clk;

  // hang guard, whole run needs under 3000 cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      give_verdict();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task check(string name, logic [67:0] seen, logic [67:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task give_verdict;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task note(int sel, int dly, logic [67:0] v);
    q.push_back('{sel, cyc + dly, v});
  endtask : note

  task tick(int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  // notes are due in order, so waiting for an empty queue is enough
  task settle;
    while (q.size() > 0) tick(1);
  endtask : settle

  function automatic rtcbk_time_t tm(logic [23:0] hms, logic p, logic [2:0] wd,
                                     logic [23:0] dmy);
    return {16'h0, hms[7:0], hms[15:8], p, hms[23:16], wd, dmy[23:16], dmy[15:8], dmy[7:0]};
  endfunction : tm

  task load(rtcbk_time_t t);
    cal_wdata = t;
    cal_load = 1'b1;
    tick(1);
    cal_load = 1'b0;
  endtask : load

  // one second at four cycles, checked between first and second advance
  task roll(logic f12, rtcbk_time_t a, rtcbk_time_t b);
    ctrl.fmt12 = f12;
    ctrl.prediv = 15'h3;
    load(a);
    note(0, 7, b);
    settle();
    ctrl.prediv = 15'h7fff;
  endtask : roll

  task pulse(logic [3:0] m, int len);
    pins = m;
    tick(len);
    pins = 4'h0;
    tick(12);
  endtask : pulse

  task refs(int n);
    repeat (n) begin
      ref_pin = 1'b1;
      tick(4);
      ref_pin = 1'b0;
      tick(4);
    end
  endtask : refs

  // ****************************************
  // monitor: oldest note against outputs
  // ****************************************
  initial begin : monitor
    rtcbk_note_t n;
    forever begin
      @(negedge core_clk);
      while (q.size() > 0 && q[0].due <= cyc) begin
        n = q.pop_front();
        case (n.sel)
          0: check("calendar", {16'h0, cal_time[51:0]}, n.v);
          1: check("backup", {36'h0, bkp_rdata}, n.v);
          2: check("flags", {60'h0, alarm_flag, tamper_flag, ts_flag, ts_ovf, wake}, n.v);
          default: check("stamp", {16'h0, ts_time[51:0]}, n.v);
        endcase
      end
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(84614));
    ctrl.prediv = 15'h7fff;
    tick(11);
    // reset values only stand until the first edge after release
    note(0, 1, tm(24'h000000, 1'b0, 3'h1, 24'h010100));
    note(2, 1, 68'h0);
    note(1, 1, 68'h0);
    tick(1);
    rst = 1'b0;
    settle();
    for (int i = 0; i < 16; i++) begin
      bkp_we = 1'b1;
      bkp_widx = i[3:0];
      bkp_wdata = $urandom;
      mem[i] = bkp_wdata;
      tick(1);
    end
    // write and read the same word back to back
    bkp_widx = 4'h3;
    bkp_ridx = 4'h3;
    bkp_wdata = $urandom;
    mem[3] = bkp_wdata;
    tick(1);
    bkp_we = 1'b0;
    note(1, 2, {36'h0, mem[3]});
    settle();
    // second pass reads after a reset in mid-run
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 16; i++) begin
        bkp_ridx = i[3:0] ^ 4'h5;
        note(1, 2, {36'h0, mem[i ^ 5]});
        settle();
      end
      rst = 1'b1;
      tick(2);
      rst = 1'b0;
    end
    roll(0, tm(24'h235959, 0, 3, 24'h280201), tm(0, 0, 4, 24'h010301));
    roll(0, tm(24'h235959, 0, 7, 24'h280204), tm(0, 0, 1, 24'h290204));
    roll(0, tm(24'h235959, 0, 2, 24'h290204), tm(0, 0, 3, 24'h010304));
    roll(0, tm(24'h235959, 0, 5, 24'h300421), tm(0, 0, 6, 24'h010521));
    roll(0, tm(24'h235959, 0, 5, 24'h300521), tm(0, 0, 6, 24'h310521));
    roll(0, tm(24'h235959, 0, 1, 24'h311299), tm(0, 0, 2, 24'h010100));
    roll(0, tm(24'h095959, 0, 1, 24'h150622), tm(24'h100000, 0, 1, 24'h150622));
    roll(1, tm(24'h115959, 0, 1, 24'h150622), tm(24'h120000, 1, 1, 24'h150622));
    roll(1, tm(24'h115959, 1, 1, 24'h150622), tm(24'h120000, 0, 2, 24'h160622));
    roll(1, tm(24'h125959, 0, 1, 24'h150622), tm(24'h010000, 0, 1, 24'h150622));
    ctrl.fmt12 = 1'b0;
    // load wins over a shift in the same cycle
    shift_req = 1'b1;
    shift_cmd = {1'b1, 15'h7fff};
    load(tm(24'h101020, 0, 1, 24'h010100));
    shift_req = 1'b0;
    note(0, 2, tm(24'h101020, 0, 1, 24'h010100));
    settle();
    tick(1);
    shift_req = 1'b1;
    tick(1);
    shift_req = 1'b0;
    note(0, 2, tm(24'h101021, 0, 1, 24'h010100));
    settle();
    al0 = {8'h05, 8'h00, 1'b0, 8'h00, 8'h00, 4'b1110};
    al1 = {8'h06, 8'h00, 1'b0, 8'h00, 8'h00, 4'b1110};
    ctrl.alarm_en = 2'b11;
    ctrl.prediv = 15'h3;
    load(tm(24'h000004, 0, 1, 24'h010100));
    note(2, 7, 68'h41);
    note(2, 11, 68'hc1);
    settle();
    ctrl.alarm_en = 2'b00;
    ctrl.prediv = 15'h7fff;
    alarm_clr = 2'b11;
    tick(1);
    alarm_clr = 2'b00;
    note(2, 2, 68'h0);
    settle();
    t0 = tm(24'h081530, 0, 3, 24'h120523);
    load(t0);
    ctrl.filt = 2'h3;
    pulse(4'b0001, 4);
    note(2, 1, 68'h0);
    pulse(4'b0001, 12);
    note(2, 1, 68'h08);
    ctrl.filt = 2'h0;
    ctrl.tamp_ie = 3'b010;
    ctrl.ts_on_tamp = 1'b1;
    pulse(4'b0010, 4);
    note(2, 1, 68'h1d);
    note(3, 1, t0);
    note(0, 1, t0);
    pulse(4'b1000, 4);
    note(2, 1, 68'h1f);
    pulse(4'b0100, 4);
    note(2, 1, 68'h3f);
    settle();
    tamper_clr = 3'h7;
    ts_clr = 1'b1;
    tick(1);
    tamper_clr = 3'h0;
    ts_clr = 1'b0;
    ctrl.ts_on_tamp = 1'b0;
    ctrl.ts_ie = 1'b1;
    note(2, 2, 68'h0);
    settle();
    pulse(4'b1000, 4);
    note(2, 1, 68'h05);
    note(3, 1, t0);
    settle();
    // reference pin paces seconds, fast prescaler must not
    ctrl.prediv = 15'h3;
    ctrl.ref_en = 1'b1;
    load(tm(24'h000000, 0, 1, 24'h010100));
    refs(49);
    note(0, 1, tm(24'h000000, 0, 1, 24'h010100));
    settle();
    refs(1);
    note(0, 1, tm(24'h000001, 0, 1, 24'h010100));
    settle();
    ctrl.ref_sel60 = 1'b1;
    refs(59);
    note(0, 1, tm(24'h000001, 0, 1, 24'h010100));
    settle();
    refs(1);
    note(0, 1, tm(24'h000002, 0, 1, 24'h010100));
    settle();
    // masked window cycles hold the prescaler right after reset
    ctrl.ref_en = 1'b0;
    ctrl.calm = 9'h010;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    note(0, 10, tm(24'h000000, 0, 1, 24'h010100));
    note(0, 18, tm(24'h000001, 0, 1, 24'h010100));
    settle();
    // extra pulses double the step early in the window
    ctrl.calm = 9'h000;
    ctrl.calp = 1'b1;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    note(0, 6, tm(24'h000003, 0, 1, 24'h010100));
    settle();
    give_verdict();
  end
endmodule : bcd_calendar_rtc_backup_tb_top

//--- rtcbk_cfg.svh
`ifndef RTCBK_CFG_SVH
`define RTCBK_CFG_SVH

// ****************************************
// sizes and counts
// ****************************************
`define RTCBK_BKP_N 16
`define RTCBK_CAL_WIN_W 20
`define RTCBK_CALP_PULSES 20'h00200
`define RTCBK_REF_50 6'h32
`define RTCBK_REF_60 6'h3c

// ****************************************
// alarm mask bit positions
// ****************************************
`define RTCBK_MSK_SEC 0
`define RTCBK_MSK_MIN 1
`define RTCBK_MSK_HOUR 2
`define RTCBK_MSK_DATE 3

// ****************************************
// reset values
// ****************************************
`define RTCBK_TIME_RST {16'h0000, 8'h00, 8'h00, 1'h0, 8'h00, 3'h1, 8'h01, 8'h01, 8'h00}

`endif

//--- rtcbk_pkg.sv
package rtcbk_pkg;

  // ****************************************
  // calendar, alarm, control and shift carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] subsec;
    logic [7:0] sec;
    logic [7:0] min;
    logic pm;
    logic [7:0] hour;
    logic [2:0] wday;
    logic [7:0] date;
    logic [7:0] month;
    logic [7:0] year;
  } rtcbk_time_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic pm;
    logic [7:0] hour;
    logic [7:0] date;
    logic [3:0] mask;
  } rtcbk_alarm_t;

  typedef struct packed {
    logic fmt12;
    logic ref_en;
    logic ref_sel60;
    logic [14:0] prediv;
    logic [8:0] calm;
    logic calp;
    logic ts_on_tamp;
    logic [1:0] filt;
    logic [1:0] alarm_en;
    logic [2:0] tamp_ie;
    logic ts_ie;
  } rtcbk_ctrl_t;

  typedef struct packed {
    logic add1s;
    logic [14:0] subfs;
  } rtcbk_shift_t;

endpackage : rtcbk_pkg

//--- rtcbk_tamp_filt.sv
`timescale 1ns/1ns
module rtcbk_tamp_filt (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pin and filter setting
  input wire logic pin,
  input wire logic [1:0] filt,
  // detection pulse
  output logic det
);
  logic [1:0] sync;
  logic prev;
  logic [3:0] cnt;
  logic [3:0] need;
  logic [3:0] next_cnt;
  logic next_det;

  // ****************************************
  // filter: edge when off, else n equal samples
  // ****************************************
  always_comb begin
    need = 4'h1 << filt;
    next_cnt = cnt;
    next_det = 1'h0;
    if (filt == 2'h0) begin
      next_det = sync[1] & ~prev;
    end else if (!sync[1]) begin
      next_cnt = 4'h0;
    end else if (cnt < need) begin
      next_cnt = cnt + 4'h1;
      next_det = (cnt == need - 4'h1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync <= 2'h0;
      prev <= 1'h0;
      cnt <= 4'h0;
      det <= 1'h0;
    end else begin
      sync <= {sync[0], pin};
      prev <= sync[1];
      cnt <= next_cnt;
      det <= next_det;
    end
  end

endmodule : rtcbk_tamp_filt

//--- rtcbk_top.sv
`timescale 1ns/1ns
`include "rtcbk_cfg.svh"
// What this block does
// - sixteen 32-bit backup words of storage
// - backup words survive every kind of reset
// - calendar kept as BCD fields
// - hour wraps by 12 or 24 hour format
// - 50/60 Hz reference can pace seconds
// - month ends after 28, 29, 30, 31
// - two alarms, each able to wake
// - shift sub-second count by 1 to 32767
// - calibration trims rate in 1 ppm steps
// - three filtered tamper inputs can wake
// - timestamp copies calendar, calendar untouched
// - timestamp from pin or tamper, can wake
module rtcbk_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // configuration
  input wire rtcbk_pkg::rtcbk_ctrl_t ctrl,
  // calendar load and shift
  input wire logic cal_load,
  input wire rtcbk_pkg::rtcbk_time_t cal_wdata,
  input wire logic shift_req,
  input wire rtcbk_pkg::rtcbk_shift_t shift_cmd,
  // alarm settings
  input wire rtcbk_pkg::rtcbk_alarm_t alarm_first,
  input wire rtcbk_pkg::rtcbk_alarm_t alarm_second,
  // pins
  input wire logic timestamp_trigger_input,
  input wire logic tamper_input_first,
  input wire logic tamper_input_second,
  input wire logic tamper_input_third,
  input wire logic ref_clk_input,
  // flag clears
  input wire logic [1:0] alarm_clr,
  input wire logic [2:0] tamper_clr,
  input wire logic ts_clr,
  // backup storage
  input wire logic bkp_we,
  input wire logic [3:0] bkp_widx,
  input wire logic [31:0] bkp_wdata,
  input wire logic [3:0] bkp_ridx,
  output logic [31:0] bkp_rdata,
  // status
  output rtcbk_pkg::rtcbk_time_t cal_time,
  output rtcbk_pkg::rtcbk_time_t ts_time,
  output logic [1:0] alarm_flag,
  output logic [2:0] tamper_flag,
  output logic ts_flag,
  output logic ts_ovf,
  output logic wake
);
  import rtcbk_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcd_inc

  function automatic logic [7:0] dim(input logic [7:0] mo, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (mo == 8'h02) begin
      dim = leap ? 8'h29 : 8'h28;
    end else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11) begin
      dim = 8'h30;
    end else begin
      dim = 8'h31;
    end
  endfunction : dim

  function automatic logic alarm_hit(input rtcbk_alarm_t a, input rtcbk_time_t t,
                                     input logic f12);
    alarm_hit = (a.mask[`RTCBK_MSK_SEC] || a.sec == t.sec)
      && (a.mask[`RTCBK_MSK_MIN] || a.min == t.min)
      && (a.mask[`RTCBK_MSK_HOUR] || (a.hour == t.hour && (!f12 || a.pm == t.pm)))
      && (a.mask[`RTCBK_MSK_DATE] || a.date == t.date);
  endfunction : alarm_hit

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] ts_sync;
  logic [1:0] ref_sync;
  logic ts_prev;
  logic ref_prev;
  logic ref_edge;
  logic ts_ev;
  logic [2:0] tamp_det;
  logic [2:0] tamp_pin;

  assign tamp_pin = {tamper_input_third, tamper_input_second, tamper_input_first};
  assign ref_edge = ref_sync[1] & ~ref_prev;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ts_sync <= 2'h0;
      ref_sync <= 2'h0;
      ts_prev <= 1'h0;
      ref_prev <= 1'h0;
    end else begin
      ts_sync <= {ts_sync[0], timestamp_trigger_input};
      ref_sync <= {ref_sync[0], ref_clk_input};
      ts_prev <= ts_sync[1];
      ref_prev <= ref_sync[1];
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_tamp
    rtcbk_tamp_filt rtcbk_tamp_filt_i (
      .core_clk(core_clk),
      .rst(rst),
      .pin(tamp_pin[i]),
      .filt(ctrl.filt),
      .det(tamp_det[i])
    );
  end

  // ****************************************
  // calendar
  // ****************************************
  logic [`RTCBK_CAL_WIN_W-1:0] cal_win;
  logic [`RTCBK_CAL_WIN_W-1:0] next_cal_win;
  logic [5:0] ref_cnt;
  logic [5:0] next_ref_cnt;
  logic [5:0] ref_top;
  logic skip;
  logic dbl;
  logic [1:0] step;
  logic sec_adv;
  logic day_adv;
  rtcbk_time_t next_cal;

  // masked or doubled steps over a 2^20 window: 1 ppm per step
  always_comb begin
    next_cal_win = cal_win + 20'h00001;
    skip = cal_win < {11'h000, ctrl.calm};
    dbl = ctrl.calp && (cal_win < `RTCBK_CALP_PULSES);
    step = skip ? {1'h0, dbl} : (dbl ? 2'h2 : 2'h1);
    ref_top = ctrl.ref_sel60 ? `RTCBK_REF_60 : `RTCBK_REF_50;
  end

  always_comb begin
    next_cal = cal_time;
    next_ref_cnt = ref_cnt;
    sec_adv = 1'h0;
    day_adv = 1'h0;
    if (cal_load) begin
      next_cal = cal_wdata;
      next_cal.subsec = {1'h0, ctrl.prediv};
      next_ref_cnt = 6'h00;
    end else begin
      if (shift_req) begin
        next_cal.subsec = cal_time.subsec + {1'h0, shift_cmd.subfs};
        sec_adv = shift_cmd.add1s;
      end else if (step != 2'h0) begin
        if (cal_time.subsec < {14'h0000, step}) begin
          next_cal.subsec = {1'h0, ctrl.prediv};
          sec_adv = !ctrl.ref_en;
        end else begin
          next_cal.subsec = cal_time.subsec - {14'h0000, step};
        end
      end
      // the reference owns the second; prescaler only fills sub-seconds
      if (ctrl.ref_en && ref_edge) begin
        if (ref_cnt >= ref_top - 6'h01) begin
          next_ref_cnt = 6'h00;
          sec_adv = 1'h1;
          next_cal.subsec = {1'h0, ctrl.prediv};
        end else begin
          next_ref_cnt = ref_cnt + 6'h01;
        end
      end
      if (sec_adv) begin
        if (next_cal.sec != 8'h59) begin
          next_cal.sec = bcd_inc(next_cal.sec);
        end else begin
          next_cal.sec = 8'h00;
          if (next_cal.min != 8'h59) begin
            next_cal.min = bcd_inc(next_cal.min);
          end else begin
            next_cal.min = 8'h00;
            if (ctrl.fmt12) begin
              if (next_cal.hour == 8'h11) begin
                next_cal.hour = 8'h12;
                next_cal.pm = ~cal_time.pm;
                day_adv = cal_time.pm;
              end else if (next_cal.hour == 8'h12) begin
                next_cal.hour = 8'h01;
              end else begin
                next_cal.hour = bcd_inc(next_cal.hour);
              end
            end else if (next_cal.hour == 8'h23) begin
              next_cal.hour = 8'h00;
              day_adv = 1'h1;
            end else begin
              next_cal.hour = bcd_inc(next_cal.hour);
            end
            if (day_adv) begin
              next_cal.wday = (next_cal.wday == 3'h7) ? 3'h1 : next_cal.wday + 3'h1;
              if (next_cal.date == dim(next_cal.month, next_cal.year)) begin
                next_cal.date = 8'h01;
                if (next_cal.month == 8'h12) begin
                  next_cal.month = 8'h01;
                  next_cal.year = (next_cal.year == 8'h99) ? 8'h00 : bcd_inc(next_cal.year);
                end else begin
                  next_cal.month = bcd_inc(next_cal.month);
                end
              end else begin
                next_cal.date = bcd_inc(next_cal.date);
              end
            end
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cal_time <= `RTCBK_TIME_RST;
      cal_win <= 20'h00000;
      ref_cnt <= 6'h00;
    end else begin
      cal_time <= next_cal;
      cal_win <= next_cal_win;
      ref_cnt <= next_ref_cnt;
    end
  end

  property p_sec_bcd;
    sec_adv && cal_time.sec == 8'h09 |=> cal_time.sec == 8'h10;
  endproperty
  a_sec_bcd: assert property (p_sec_bcd) else $error("seconds bcd carry wrong");

  property p_hour24;
    sec_adv && !ctrl.fmt12 && cal_time.hour == 8'h23 && cal_time.min == 8'h59
      && cal_time.sec == 8'h59 |=> cal_time.hour == 8'h00;
  endproperty
  a_hour24: assert property (p_hour24) else $error("24 hour wrap wrong");

  property p_ref_sec;
    !cal_load && !shift_req && ctrl.ref_en && ref_edge && ref_cnt == ref_top - 6'h01
      |=> cal_time.subsec == {1'h0, $past(ctrl.prediv)};
  endproperty
  a_ref_sec: assert property (p_ref_sec) else $error("reference second missed");

  property p_month_end;
    sec_adv && !ctrl.fmt12 && cal_time.hour == 8'h23 && cal_time.min == 8'h59
      && cal_time.sec == 8'h59 && cal_time.date == dim(cal_time.month, cal_time.year)
      |=> cal_time.date == 8'h01;
  endproperty
  a_month_end: assert property (p_month_end) else $error("month end rollover wrong");

  property p_shift;
    shift_req && !cal_load |=>
      cal_time.subsec == $past(cal_time.subsec) + {1'h0, $past(shift_cmd.subfs)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift not applied");

  property p_cal_skip;
    skip && !dbl && !cal_load && !shift_req && !ref_edge |=> $stable(cal_time.subsec);
  endproperty
  a_cal_skip: assert property (p_cal_skip) else $error("masked pulse counted");

  property p_pm;
    sec_adv && ctrl.fmt12 && cal_time.hour == 8'h11 && cal_time.min == 8'h59
      && cal_time.sec == 8'h59 |=> cal_time.hour == 8'h12 && cal_time.pm != $past(cal_time.pm);
  endproperty
  a_pm: assert property (p_pm) else $error("pm toggle wrong");

  // ****************************************
  // alarms, tamper, timestamp, wake
  // ****************************************
  rtcbk_alarm_t alm [2];
  logic [1:0] hit;
  logic [1:0] next_alarm_flag;
  logic [2:0] next_tamper_flag;
  logic next_ts_flag;
  logic next_ts_ovf;
  logic next_wake;
  rtcbk_time_t next_ts_time;

  assign alm = '{alarm_first, alarm_second};
  for (genvar i = 0; i < 2; i++) begin : g_alm
    assign hit[i] = sec_adv && ctrl.alarm_en[i] && alarm_hit(alm[i], next_cal, ctrl.fmt12);
  end

  // a new event wins over a clear in the same cycle
  always_comb begin
    ts_ev = (ts_sync[1] & ~ts_prev) | (ctrl.ts_on_tamp & (|tamp_det));
    next_alarm_flag = (alarm_flag & ~alarm_clr) | hit;
    next_tamper_flag = (tamper_flag & ~tamper_clr) | tamp_det;
    next_ts_flag = (ts_flag & ~ts_clr) | ts_ev;
    next_ts_ovf = (ts_ovf & ~ts_clr) | (ts_ev & ts_flag);
    next_ts_time = ts_ev ? cal_time : ts_time;
    next_wake = (|next_alarm_flag) | (|(next_tamper_flag & ctrl.tamp_ie))
      | (next_ts_flag & ctrl.ts_ie);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_flag <= 2'h0;
      tamper_flag <= 3'h0;
      ts_flag <= 1'h0;
      ts_ovf <= 1'h0;
      ts_time <= `RTCBK_TIME_RST;
      wake <= 1'h0;
    end else begin
      alarm_flag <= next_alarm_flag;
      tamper_flag <= next_tamper_flag;
      ts_flag <= next_ts_flag;
      ts_ovf <= next_ts_ovf;
      ts_time <= next_ts_time;
      wake <= next_wake;
    end
  end

  property p_alarm;
    hit[0] |=> alarm_flag[0] && wake;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm did not flag or wake");

  property p_tamp;
    tamp_det[1] && ctrl.tamp_ie[1] |=> tamper_flag[1] && wake;
  endproperty
  a_tamp: assert property (p_tamp) else $error("tamper did not flag or wake");

  property p_ts_cap;
    ts_ev |=> ts_time == $past(cal_time) && ts_flag;
  endproperty
  a_ts_cap: assert property (p_ts_cap) else $error("timestamp capture wrong");

  property p_ts_tamp;
    ctrl.ts_on_tamp && tamp_det[2] |=> ts_flag;
  endproperty
  a_ts_tamp: assert property (p_ts_tamp) else $error("tamper did not timestamp");

  // ****************************************
  // backup storage
  // ****************************************
  logic [31:0] bkp [`RTCBK_BKP_N];

  // no reset on purpose: contents must outlive any reset
  always_ff @(posedge core_clk) begin
    if (bkp_we) begin
      bkp[bkp_widx] <= bkp_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bkp_rdata <= 32'h00000000;
    end else begin
      bkp_rdata <= bkp[bkp_ridx];
    end
  end

  sequence s_bkp_wr;
    bkp_we && bkp_ridx == bkp_widx ##1 !bkp_we && $stable(bkp_ridx);
  endsequence

  property p_bkp;
    s_bkp_wr |=> bkp_rdata == $past(bkp_wdata, 2);
  endproperty
  a_bkp: assert property (p_bkp) else $error("backup word not kept");

endmodule : rtcbk_top
